/* File: pkg/dvc_fifo_if.sv */
`timescale 1ns/1ns
interface dvc_fifo_if #(
  parameter int WIDTH = 48
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport user (
    output push_valid,
    output push_data,
    input push_ready,
    input pop_valid,
    input pop_data,
    output pop_ready
  );

  modport store (
    input push_valid,
    input push_data,
    output push_ready,
    output pop_valid,
    output pop_data,
    input pop_ready
  );
endinterface

/* File: pkg/dvc_pkg.sv */
package dvc_pkg;

  // Register offsets
  localparam logic [6:0] PWR2_ADDR = 7'h03;
  localparam logic [6:0] CTL1_ADDR = 7'h15;
  localparam logic [6:0] CTL2_ADDR = 7'h16;
  localparam logic [6:0] LVOL_ADDR = 7'h17;

  // Field positions
  localparam int LEFT_ENABLE_BIT = 0;
  localparam int RIGHT_ENABLE_BIT = 1;
  localparam int GLOBAL_MUTE_BIT = 8;
  localparam int RAMP_ENABLE_BIT = 4;
  localparam int VOLUME_UPDATE_BIT = 12;
  localparam int LEFT_MUTE_BIT = 8;

  // Reset values
  localparam logic [1:0] ENABLE_RST = 2'h0;
  localparam logic GLOBAL_MUTE_RST = 1'h1;
  localparam logic RAMP_ENABLE_RST = 1'h1;
  localparam logic LEFT_MUTE_RST = 1'h0;
  localparam logic [7:0] VOLUME_RST = 8'hC0;

  // Gain arithmetic: code 0xC0 is unity, 16 codes per octave of shift
  localparam logic [7:0] MUTE_CODE = 8'h00;
  localparam logic [8:0] GAIN_OFFSET = 9'h040;
  localparam int MANT_FRAC_BITS = 14;
  localparam int UNITY_SHIFT = 16;
  localparam int SAMPLE_WIDTH = 24;
  localparam int CHANNELS = 2;

  // Samples per ramp step: gain moves at fs/2
  localparam logic RAMP_PHASE_LAST = 1'h1;

  // 10^(0.375*k/20) in Q14, k = 0..15; element k is index k
  localparam logic [15:0][15:0] GAIN_MANT = {
    16'h7A4C, 16'h7522, 16'h702E, 16'h6B71, 16'h66E8, 16'h628E, 16'h5E65, 16'h5A67,
    16'h5696, 16'h52EC, 16'h4F6B, 16'h4C11, 16'h48DB, 16'h45C6, 16'h42D3, 16'h4000
  };

  typedef enum logic [1:0] {
    DVC_RAMP_IDLE = 2'b00,
    DVC_RAMP_UP = 2'b01,
    DVC_RAMP_DOWN = 2'b10
  } dvc_ramp_state_type;

endpackage

/* File: verif/dvc_sample_source.sv */
`timescale 1ns/1ns
module dvc_sample_source #(
  parameter logic [7:0] TAG = 8'h10
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic i_ready,
  output logic o_valid,
  output logic [23:0] o_left,
  output logic [23:0] o_right
);
  logic [15:0] count_q;
  logic took_q;
  logic [15:0] nxt;
  always @(posedge i_clk) begin
    took_q <= o_valid && i_ready;
  end
  // Frame n: left carries TAG, right its inverse (negative), n in low bits
  always @(negedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= 16'h0000;
      o_valid <= 1'b0;
      o_left <= 24'h000000;
      o_right <= 24'h000000;
    end else begin
      nxt = took_q ? count_q + 16'h0001 : count_q;
      count_q <= nxt;
      // A frame offered stays until taken
      o_valid <= i_enable || (o_valid && !took_q);
      if (i_enable || (o_valid && !took_q)) begin
        o_left <= {TAG, nxt};
        o_right <= {~TAG, nxt};
      end else begin
        o_left <= ~o_left;
        o_right <= ~o_right;
      end
    end
  end
endmodule

/* File: verif/test_dvc_volume_control.sv */
`timescale 1ns/1ns
module test_dvc_volume_control;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_reg_we = 1'b0;
  logic i_reg_re = 1'b0;
  logic [6:0] i_reg_addr = 7'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_dsp_route = 1'b0;
  logic i_out_ready = 1'b0;
  logic en_a = 1'b1;
  logic en_d = 1'b1;
  logic [15:0] o_reg_rdata;
  logic a_valid, d_valid, o_in_ready, o_left_power, o_right_power, o_out_valid;
  logic [23:0] a_left, a_right, d_left, d_right, o_out_left, o_out_right;
  logic [7:0] o_left_gain, o_right_gain;
  logic [23:0] s_l, s_r, in_l, in_r;
  logic [7:0] g [0:7];
  logic [15:0] exp_n = 16'h0000;
  int miscompares = 0;
  int check_count = 0;
  logic [6:0] ra [0:4] = '{7'h03, 7'h15, 7'h16, 7'h17, 7'h20};
  logic [15:0] rv [0:4] = '{16'h0000, 16'h0100, 16'h0010, 16'h00C0, 16'h0000};

  always #5 i_clk = ~i_clk;

  dvc_volume_control #(.FIFO_DEPTH(8)) dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_reg_we(i_reg_we), .i_reg_re(i_reg_re), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_dsp_route(i_dsp_route),
    .i_aif_valid(a_valid), .i_aif_left(a_left), .i_aif_right(a_right),
    .i_dsp_valid(d_valid), .i_dsp_left(d_left), .i_dsp_right(d_right),
    .o_in_ready(o_in_ready), .o_left_power(o_left_power), .o_right_power(o_right_power),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_left(o_out_left),
    .o_out_right(o_out_right), .o_left_gain(o_left_gain), .o_right_gain(o_right_gain));
  dvc_sample_source #(.TAG(8'h10)) src_a (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_enable(en_a), .i_ready(o_in_ready && !i_dsp_route), .o_valid(a_valid),
    .o_left(a_left), .o_right(a_right));
  dvc_sample_source #(.TAG(8'h20)) src_d (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_enable(en_d), .i_ready(o_in_ready && i_dsp_route), .o_valid(d_valid),
    .o_left(d_left), .o_right(d_right));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_we = 1'b1;
    @(negedge i_clk);
    i_reg_we = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    i_reg_addr = a;
    i_reg_re = 1'b1;
    @(negedge i_clk);
    i_reg_re = 1'b0;
    chk({8'h00, o_reg_rdata}, {8'h00, e});
  endtask

  // Take one output frame; the sink stalls between calls
  task automatic get;
    int k;
    k = 0;
    while (o_out_valid !== 1'b1 && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    chk({23'h0, o_out_valid}, 24'h000001);
    s_l = o_out_left;
    s_r = o_out_right;
    in_l = {8'h10, exp_n};
    in_r = {8'hEF, exp_n};
    exp_n++;
    i_out_ready = 1'b1;
    @(negedge i_clk);
    i_out_ready = 1'b0;
  endtask

  task automatic skip(input int n);
    repeat (n) get();
  endtask

  task automatic conclude;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    chk({22'h0, o_left_power, o_right_power}, 24'h0);
    wr(7'h16, 16'h0000);
    wr(7'h03, 16'h0003);
    chk({22'h0, o_left_power, o_right_power}, 24'h3);
    wr(7'h15, 16'h0000);
    skip(2);
    get();
    chk({o_left_gain, o_right_gain, 8'h00}, 24'hC0C000);
    chk(s_l, in_l);
    chk(s_r, in_r);
    wr(7'h17, 16'h00B0);
    rd(7'h17, 16'h00B0);
    skip(2);
    chk({16'h0, o_left_gain}, 24'hC0);
    wr(7'h17, 16'h10B0);
    skip(2);
    get();
    chk({16'h0, o_left_gain}, 24'hB0);
    chk(s_l, {in_l[23], in_l[23:1]});
    chk(s_r, {in_r[23], in_r[23:1]});
    wr(7'h17, 16'h1000);
    skip(2);
    get();
    chk(s_l | s_r, 24'h0);
    wr(7'h17, 16'h11C0);
    skip(3);
    get();
    chk({o_left_gain, o_right_gain, 8'h00}, 24'h00C000);
    chk(s_l, 24'h0);
    chk(s_r, in_r);
    wr(7'h15, 16'h0100);
    skip(2);
    get();
    chk(s_r, 24'h0);
    wr(7'h17, 16'h00C0);
    wr(7'h16, 16'h0010);
    wr(7'h15, 16'h0000);
    skip(2);
    for (int i = 0; i < 8; i++) begin
      g[i] = o_left_gain;
      get();
    end
    for (int i = 0; i < 6; i++) chk({16'h0, g[i + 2]}, {16'h0, g[i] + 8'h01});
    chk({16'h0, o_right_gain}, {16'h0, o_left_gain});
    wr(7'h03, 16'h0001);
    skip(2);
    get();
    chk({23'h0, o_right_power}, 24'h0);
    chk(s_r, 24'h0);
    repeat (20) @(negedge i_clk);
    chk({23'h0, o_in_ready}, 24'h0);
    en_a = 1'b0;
    skip(10);
    repeat (4) @(negedge i_clk);
    chk({22'h0, o_out_valid, o_in_ready}, 24'h1);
    wr(7'h16, 16'h0000);
    wr(7'h03, 16'h0003);
    i_dsp_route = 1'b1;
    skip(3);
    get();
    chk({s_l[23:16], s_r[23:16], o_left_gain}, 24'h20DFC0);
    conclude();
  end
endmodule

/* File: verilog/dvc_fifo.sv */
`timescale 1ns/1ns
module dvc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  dvc_fifo_if.store bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] COUNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
  } dvc_fifo_state_type;

  dvc_fifo_state_type st_q;
  dvc_fifo_state_type st_d;
  logic push;
  logic pop;

  assign push = bus.push_valid && st_q.in_ready;
  assign pop = bus.pop_ready && st_q.out_valid;
  assign bus.push_ready = st_q.in_ready;
  assign bus.pop_valid = st_q.out_valid;
  assign bus.pop_data = st_q.mem[st_q.rd];

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = bus.push_data;
      st_d.wr = (st_q.wr == PTR_LAST) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == PTR_LAST) ? '0 : st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
    // Flags kept as flops so ready and valid leave without logic
    st_d.in_ready = (st_d.count != COUNT_FULL);
    st_d.out_valid = (st_d.count != '0);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
      st_q.in_ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

/* File: verilog/dvc_volume_control.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Each converter channel is powered and passes data only while its enable bit is set.
// - Gain is 0.375 dB times (code minus 192); code zero mutes.
// - Written volume waits; it becomes active only when the update bit is written one.
// - The left channel is silenced by its own mute or by the global mute; the right channel only by the global mute.
// - Global mute comes out of reset set.
// - With ramp enabled, mute, unmute and volume changes move gain gradually.
// - Ramped gain advances one step every two samples.
// - Left volume code resets to 0xC0, unity gain.
// - Samples come from the audio interface or, by mode, the DSP core.
// - Samples reach the interpolation filter at full 24-bit precision.
module dvc_volume_control #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [6:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_dsp_route,
  input wire logic i_aif_valid,
  input wire logic [23:0] i_aif_left,
  input wire logic [23:0] i_aif_right,
  input wire logic i_dsp_valid,
  input wire logic [23:0] i_dsp_left,
  input wire logic [23:0] i_dsp_right,
  output logic o_in_ready,
  output logic o_left_power,
  output logic o_right_power,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [23:0] o_out_left,
  output logic [23:0] o_out_right,
  output logic [7:0] o_left_gain,
  output logic [7:0] o_right_gain
);
  localparam int SW = dvc_pkg::SAMPLE_WIDTH;
  localparam int NCH = dvc_pkg::CHANNELS;
  localparam int DROP = dvc_pkg::UNITY_SHIFT + dvc_pkg::MANT_FRAC_BITS;
  localparam logic signed [63:0] SAT_MAX = 64'sh00000000007FFFFF;
  localparam logic signed [63:0] SAT_MIN = -64'sh0000000000800000;

  typedef struct packed {
    logic [1:0] enable;
    logic global_mute;
    logic ramp_en;
    logic left_mute;
    logic [7:0] vol_pend;
    logic [7:0] vol_act;
    logic [NCH-1:0][7:0] gain_cur;
    dvc_pkg::dvc_ramp_state_type [NCH-1:0] rstate;
    logic ramp_ph;
    logic [15:0] rdata;
    logic out_valid;
    logic [NCH-1:0][SW-1:0] out_smp;
    logic [NCH-1:0][7:0] out_gain;
  } dvc_state_type;

  dvc_state_type st_q;
  dvc_state_type st_d;
  logic pop;
  logic [NCH-1:0][7:0] target;
  logic [NCH-1:0] ch_mute;

  dvc_fifo_if #(.WIDTH(2 * SW)) ff ();

  dvc_fifo #(
    .WIDTH(2 * SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .bus(ff.store)
  );

  // Source choice by DSP routing mode
  assign ff.push_valid = i_dsp_route ? i_dsp_valid : i_aif_valid;
  assign ff.push_data = i_dsp_route ? {i_dsp_right, i_dsp_left} : {i_aif_right, i_aif_left};
  assign ff.pop_ready = !st_q.out_valid || i_out_ready;
  assign pop = ff.pop_valid && ff.pop_ready;
  assign o_in_ready = ff.push_ready;

  // Gain by mantissa table and power-of-two shift
  function automatic logic [SW-1:0] apply_gain(
    input logic signed [SW-1:0] smp,
    input logic [7:0] code
  );
    logic [8:0] n;
    logic [4:0] sh;
    logic signed [40:0] prod;
    logic signed [63:0] wide;
    n = {1'b0, code} + dvc_pkg::GAIN_OFFSET;
    sh = n[8:4];
    prod = smp * $signed({1'b0, dvc_pkg::GAIN_MANT[n[3:0]]});
    wide = 64'(prod) <<< sh;
    wide = wide >>> DROP;
    if (code == dvc_pkg::MUTE_CODE) begin
      apply_gain = '0;
    end else if (wide > SAT_MAX) begin
      apply_gain = SAT_MAX[SW-1:0];
    end else if (wide < SAT_MIN) begin
      apply_gain = SAT_MIN[SW-1:0];
    end else begin
      apply_gain = wide[SW-1:0];
    end
  endfunction

  // Only the left channel has its own mute bit
  assign ch_mute = {1'b0, st_q.left_mute};

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_target
      assign target[c] = (ch_mute[c] || st_q.global_mute) ? dvc_pkg::MUTE_CODE
                                                           : st_q.vol_act;
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    if (i_reg_we) begin
      if (i_reg_addr == dvc_pkg::PWR2_ADDR) begin
        st_d.enable[0] = i_reg_wdata[dvc_pkg::LEFT_ENABLE_BIT];
        st_d.enable[1] = i_reg_wdata[dvc_pkg::RIGHT_ENABLE_BIT];
      end else if (i_reg_addr == dvc_pkg::CTL1_ADDR) begin
        st_d.global_mute = i_reg_wdata[dvc_pkg::GLOBAL_MUTE_BIT];
      end else if (i_reg_addr == dvc_pkg::CTL2_ADDR) begin
        st_d.ramp_en = i_reg_wdata[dvc_pkg::RAMP_ENABLE_BIT];
      end else if (i_reg_addr == dvc_pkg::LVOL_ADDR) begin
        st_d.left_mute = i_reg_wdata[dvc_pkg::LEFT_MUTE_BIT];
        st_d.vol_pend = i_reg_wdata[7:0];
        if (i_reg_wdata[dvc_pkg::VOLUME_UPDATE_BIT]) begin
          st_d.vol_act = i_reg_wdata[7:0];
        end
      end
    end
    if (i_reg_re) begin
      st_d.rdata = '0;
      if (i_reg_addr == dvc_pkg::PWR2_ADDR) begin
        st_d.rdata[1:0] = st_q.enable;
      end else if (i_reg_addr == dvc_pkg::CTL1_ADDR) begin
        st_d.rdata[dvc_pkg::GLOBAL_MUTE_BIT] = st_q.global_mute;
      end else if (i_reg_addr == dvc_pkg::CTL2_ADDR) begin
        st_d.rdata[dvc_pkg::RAMP_ENABLE_BIT] = st_q.ramp_en;
      end else if (i_reg_addr == dvc_pkg::LVOL_ADDR) begin
        // Update bit is a strobe and reads zero
        st_d.rdata[dvc_pkg::LEFT_MUTE_BIT] = st_q.left_mute;
        st_d.rdata[7:0] = st_q.vol_pend;
      end
    end
    if (st_q.out_valid && i_out_ready) begin
      st_d.out_valid = 1'b0;
    end
    for (int c = 0; c < NCH; c++) begin
      if (st_q.gain_cur[c] < target[c]) begin
        st_d.rstate[c] = dvc_pkg::DVC_RAMP_UP;
      end else if (st_q.gain_cur[c] > target[c]) begin
        st_d.rstate[c] = dvc_pkg::DVC_RAMP_DOWN;
      end else begin
        st_d.rstate[c] = dvc_pkg::DVC_RAMP_IDLE;
      end
    end
    if (pop) begin
      st_d.out_valid = 1'b1;
      st_d.ramp_ph = ~st_q.ramp_ph;
      for (int c = 0; c < NCH; c++) begin
        // Full-width sample to the interpolation filter
        if (st_q.enable[c]) begin
          st_d.out_smp[c] = apply_gain(ff.pop_data[c*SW +: SW], st_q.gain_cur[c]);
        end else begin
          st_d.out_smp[c] = '0;
        end
        st_d.out_gain[c] = st_q.gain_cur[c];
        if (!st_q.ramp_en) begin
          st_d.gain_cur[c] = target[c];
        end else if (st_q.ramp_ph == dvc_pkg::RAMP_PHASE_LAST) begin
          case (st_d.rstate[c])
            dvc_pkg::DVC_RAMP_UP: begin
              st_d.gain_cur[c] = st_q.gain_cur[c] + 8'h01;
            end
            dvc_pkg::DVC_RAMP_DOWN: begin
              st_d.gain_cur[c] = st_q.gain_cur[c] - 8'h01;
            end
            default: begin
              st_d.gain_cur[c] = st_q.gain_cur[c];
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
      st_q.enable <= dvc_pkg::ENABLE_RST;
      st_q.global_mute <= dvc_pkg::GLOBAL_MUTE_RST;
      st_q.ramp_en <= dvc_pkg::RAMP_ENABLE_RST;
      st_q.left_mute <= dvc_pkg::LEFT_MUTE_RST;
      st_q.vol_pend <= dvc_pkg::VOLUME_RST;
      st_q.vol_act <= dvc_pkg::VOLUME_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata = st_q.rdata;
  assign o_left_power = st_q.enable[0];
  assign o_right_power = st_q.enable[1];
  assign o_out_valid = st_q.out_valid;
  assign o_out_left = st_q.out_smp[0];
  assign o_out_right = st_q.out_smp[1];
  assign o_left_gain = st_q.out_gain[0];
  assign o_right_gain = st_q.out_gain[1];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_enable_write: assert property (i_reg_we && i_reg_addr == dvc_pkg::PWR2_ADDR
      |=> o_left_power == $past(i_reg_wdata[0]) && o_right_power == $past(i_reg_wdata[1]))
    else $error("enable bits did not follow write");
  a_disabled_silent: assert property (pop && !st_q.enable[0] |=> o_out_left == '0)
    else $error("disabled left channel passed data");
  a_right_disabled: assert property (pop && !st_q.enable[1] |=> o_out_right == '0)
    else $error("disabled right channel passed data");
  a_mute_code_zero: assert property (o_out_valid && o_left_gain == 8'h00 |-> o_out_left == '0)
    else $error("zero volume code did not mute");
  a_vu_held: assert property (i_reg_we && i_reg_addr == dvc_pkg::LVOL_ADDR
      && !i_reg_wdata[dvc_pkg::VOLUME_UPDATE_BIT] |=> $stable(st_q.vol_act))
    else $error("volume loaded without update bit");
  a_vu_load: assert property (i_reg_we && i_reg_addr == dvc_pkg::LVOL_ADDR
      && i_reg_wdata[dvc_pkg::VOLUME_UPDATE_BIT] |=> st_q.vol_act == $past(i_reg_wdata[7:0]))
    else $error("update bit did not load volume");
  a_mute_target: assert property (st_q.global_mute || st_q.left_mute |-> target[0] == 8'h00)
    else $error("muted left channel has nonzero target");
  a_right_mute: assert property (st_q.global_mute |-> target[1] == 8'h00)
    else $error("globally muted right channel has nonzero target");
  a_update_reads_zero: assert property (i_reg_re && i_reg_addr == dvc_pkg::LVOL_ADDR
      |=> !o_reg_rdata[dvc_pkg::VOLUME_UPDATE_BIT])
    else $error("volume update bit did not read zero");
  a_reset_values: assert property ($rose(i_resetn) |-> st_q.global_mute
      && st_q.vol_act == 8'hC0 && st_q.ramp_en)
    else $error("wrong control values after reset");
  a_ramp_single: assert property ($changed(st_q.gain_cur[0]) && $past(st_q.ramp_en)
      |-> (st_q.gain_cur[0] - $past(st_q.gain_cur[0]) == 8'h01)
       || ($past(st_q.gain_cur[0]) - st_q.gain_cur[0] == 8'h01))
    else $error("ramped gain moved more than one step");
  a_ramp_rate: assert property ($changed(st_q.gain_cur[1]) && $past(st_q.ramp_en)
      |-> $past(pop) && !st_q.ramp_ph)
    else $error("ramped gain moved off the half-rate tick");
  a_step_no_ramp: assert property (pop && !st_q.ramp_en |=> st_q.gain_cur[0] == $past(target[0]))
    else $error("unramped change was not a step");

  c_ramp_down: cover property (st_q.ramp_en && st_q.rstate[0] == dvc_pkg::DVC_RAMP_DOWN
      ##1 st_q.rstate[0] == dvc_pkg::DVC_RAMP_IDLE);
  c_fifo_full: cover property (!o_in_ready ##1 o_in_ready);
  c_vu_load: cover property (i_reg_we && i_reg_addr == dvc_pkg::LVOL_ADDR
      && i_reg_wdata[dvc_pkg::VOLUME_UPDATE_BIT]);
  c_unity_out: cover property (o_out_valid && o_left_gain == 8'hC0 && i_out_ready);
  // Samples taken through the DSP route
  c_dsp_route: cover property (i_dsp_route && i_dsp_valid && o_in_ready);
endmodule
